// >>> tws_master.sv
// Behavioural two-wire bus master for the slave bench
`timescale 1ns/100ps
module tws_master (
  // Clock
  input wire logic sys_clk,
  // Bus lines
  input wire logic sda_line,
  output logic scl,
  output logic sda_rel
);
  // Idle bus: both lines released high
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  // Data moves mid-low, sampled mid-high; 8 clocks per phase for the input filter
  task automatic bit_x(input logic b, output logic r);
    tick(4);
    sda_rel = b;
    tick(4);
    scl = 1'b1;
    tick(4);
    r = sda_line;
    tick(4);
    scl = 1'b0;
  endtask
  // Data released before clock rises, so a stuck line shows first
  task automatic start();
    tick(4);
    sda_rel = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_rel = 1'b0;
    tick(8);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(4);
    sda_rel = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_rel = 1'b1;
    tick(8);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  // Last byte of a read is left unacknowledged
  task automatic recv(input logic more, output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      q[i] = r;
    end
    bit_x(~more, r);
  endtask
endmodule

// >>> tws_mem.sv
// Byte array with registered read port
`timescale 1ns/100ps
module tws_mem (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Write port
  input wire logic wr_en,
  input wire logic [tws_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [tws_pkg::DATA_W-1:0] wr_data,
  // Read port
  input wire logic [tws_pkg::ADDR_W-1:0] rd_addr,
  output logic [tws_pkg::DATA_W-1:0] rd_data_q
);
  import tws_pkg::*;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= DATA_RST;
    end else begin
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule

// >>> tws_pkg.sv
// Constants, state encoding and summary for the two-wire EEPROM slave front end
// Summary of operation
// - Data line only pulled low or released
// - Write-protect high blocks every array change
// - Floating chip-select input compares as zero
// - Data changes only while clock low
// - Start is data fall, clock high
// - Stop is data rise, clock high; ends operation
// - Receiver pulls data low on ninth pulse
// - Any Start resets protocol logic
// - Standby after power-up, read Stop, write end
// - Array accesses need prefix 1010
// - Address bit 3 must match chip-select
// - Bits 2 and 1 select 256-byte block
// - Bit 0 selects read or write
// - Byte write: address, offset, data, Stop programs
// - Page write increments low four bits only
// - Over sixteen bytes overwrite earlier page bytes
// - One self-timed cycle programs whole page
// - Address not acknowledged while programming runs
// - Counter holds last location plus one
// - Array is 1024 bytes, 16-byte pages
// - Master acknowledge fetches next sequential byte
package tws_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int PAGE_W = 4;
  localparam int PAGE_BYTES = 16;
  localparam logic [3:0] ARRAY_PREFIX = 4'hA;
  localparam int DEV_CS_BIT = 3;
  localparam int DEV_BLK_HI = 2;
  localparam int DEV_BLK_LO = 1;
  localparam int DEV_DIR_BIT = 0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  // Input synchroniser lanes
  localparam int SYNC_W = 4;
  localparam int IN_SCL = 0;
  localparam int IN_SDA = 1;
  localparam int IN_WP = 2;
  localparam int IN_CS = 3;
  localparam logic [SYNC_W-1:0] SYNC_RST = 4'h3;
  // Self-timed write cycle
  localparam int CLK_MHZ = 40;
  localparam int WRITE_TIME_US = 4000;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  typedef enum logic [5:0] {
    TWS_IDLE   = 6'h01,
    TWS_RX     = 6'h02,
    TWS_ACK    = 6'h04,
    TWS_TX     = 6'h08,
    TWS_MACK   = 6'h10,
    TWS_IGNORE = 6'h20
  } tws_state_t;
endpackage

// >>> tws_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module tws_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Raw and filtered levels
  input wire logic [tws_pkg::SYNC_W-1:0] raw,
  output logic [tws_pkg::SYNC_W-1:0] level_q
);
  import tws_pkg::*;
  genvar i;
  generate
    for (i = 0; i < SYNC_W; i++) begin : g_lane
      logic f1_q;
      logic f2_q;
      logic f3_q;
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          f1_q <= SYNC_RST[i];
          f2_q <= SYNC_RST[i];
          f3_q <= SYNC_RST[i];
          level_q[i] <= SYNC_RST[i];
        end else begin
          f1_q <= raw[i];
          f2_q <= f1_q;
          f3_q <= f2_q;
          // Only accept a level once two late stages agree
          if (f2_q == f3_q) begin
            level_q[i] <= f2_q;
          end
        end
      end
    end
  endgenerate
endmodule

// >>> tws_top.sv
// Two-wire EEPROM slave: protocol engine, page latch and write timer
`timescale 1ns/100ps
module tws_top #(
  parameter int WR_CYCLES = tws_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Strap and protect pins
  input wire logic chip_select_pin,
  input wire logic write_protect,
  // Status
  output logic busy,
  output logic standby
);
  import tws_pkg::*;
  localparam int TMR_W = $clog2(WR_CYCLES + 1);
  localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(WR_CYCLES - 1);

  logic [SYNC_W-1:0] pins_f;
  logic scl_f;
  logic sda_f;
  logic wp_f;
  logic cs_f;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  tws_state_t state_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [DATA_W-1:0] shift_q;
  logic [DATA_W-1:0] tx_q;
  logic dir_q;
  logic [1:0] blk_q;
  logic [ADDR_W-1:0] addr_q;
  logic sda_oe_q;
  logic standby_q;

  logic byte_done;
  logic addr_match;
  logic ack_ok;
  logic latch_en;
  logic tx_done;

  logic [DATA_W-1:0] pg_data [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] pg_valid_q;
  logic prog_q;
  logic [PAGE_W-1:0] prog_idx_q;
  logic [ADDR_W-PAGE_W-1:0] prog_page_q;
  logic [TMR_W-1:0] tmr_q;
  logic busy_q;
  logic launch;
  logic [DATA_W-1:0] rd_data;
  logic [4:0] prog_len_q;

  tws_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .raw({chip_select_pin, write_protect, sda_in, scl_in}),
    .level_q(pins_f)
  );

  assign scl_f = pins_f[IN_SCL];
  assign sda_f = pins_f[IN_SDA];
  assign wp_f = pins_f[IN_WP];
  // External pull-down keeps a floating strap at zero
  assign cs_f = pins_f[IN_CS];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_p_q;
  assign scl_fall = ~scl_f & scl_p_q;
  // Data edges with clock held high are bus conditions
  assign start_c = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop_c = scl_f & scl_p_q & ~sda_p_q & sda_f;

  // Byte decode at the falling edge after the eighth bit
  assign byte_done = (state_q == TWS_RX) && scl_fall && (bit_q == 4'd8);
  assign addr_match = (shift_q[7:4] == ARRAY_PREFIX) && (shift_q[DEV_CS_BIT] == cs_f);
  assign ack_ok = (byte_q == 2'd0) ? (addr_match & ~busy_q) : 1'b1;
  assign latch_en = byte_done && (byte_q == 2'd2) && !dir_q && !wp_f && !busy_q;
  assign tx_done = (state_q == TWS_TX) && scl_fall && (bit_q == 4'd7);

  // Protocol sequencer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= TWS_IDLE;
      bit_q <= 4'd0;
      byte_q <= 2'd0;
      shift_q <= DATA_RST;
      tx_q <= DATA_RST;
      dir_q <= 1'b0;
      blk_q <= 2'b00;
    end else if (start_c) begin
      state_q <= TWS_RX;
      bit_q <= 4'd0;
      byte_q <= 2'd0;
    end else if (stop_c) begin
      state_q <= TWS_IDLE;
      bit_q <= 4'd0;
    end else begin
      case (state_q)
        TWS_IDLE: begin
          state_q <= TWS_IDLE;
        end
        TWS_IGNORE: begin
          state_q <= TWS_IGNORE;
        end
        TWS_RX: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_f};
            bit_q <= bit_q + 4'd1;
          end else if (byte_done) begin
            bit_q <= 4'd0;
            state_q <= ack_ok ? TWS_ACK : TWS_IGNORE;
            if (byte_q == 2'd0) begin
              dir_q <= shift_q[DEV_DIR_BIT];
              blk_q <= shift_q[DEV_BLK_HI:DEV_BLK_LO];
            end
          end
        end
        TWS_ACK: begin
          if (scl_fall) begin
            byte_q <= (byte_q == 2'd2) ? 2'd2 : byte_q + 2'd1;
            if (dir_q) begin
              state_q <= TWS_TX;
              tx_q <= rd_data;
            end else begin
              state_q <= TWS_RX;
            end
          end
        end
        TWS_TX: begin
          if (scl_fall) begin
            // New bit only after the clock has gone low
            tx_q <= {tx_q[6:0], 1'b0};
            bit_q <= bit_q + 4'd1;
            if (tx_done) begin
              bit_q <= 4'd0;
              state_q <= TWS_MACK;
            end
          end
        end
        TWS_MACK: begin
          if (scl_rise && sda_f) begin
            state_q <= TWS_IGNORE;
          end else if (scl_fall) begin
            state_q <= TWS_TX;
            tx_q <= rd_data;
          end
        end
        default: begin
          state_q <= TWS_IDLE;
        end
      endcase
    end
  end

  // Address counter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_q <= ADDR_RST;
    end else if (byte_done && ack_ok && !dir_q && (byte_q == 2'd1) && !busy_q) begin
      addr_q <= {blk_q, shift_q};
    end else if (latch_en) begin
      // Page wrap keeps the upper bits fixed
      addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] + 4'd1;
    end else if (tx_done) begin
      addr_q <= addr_q + 10'h001;
    end
  end

  // Open-drain drive: only ever pulls low
  assign sda_out = 1'b0;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sda_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= (state_q == TWS_ACK) || ((state_q == TWS_TX) && !tx_q[7]);
    end
  end
  assign sda_oe = sda_oe_q;

  // Page latch, one entry per byte of the page
  genvar gi;
  generate
    for (gi = 0; gi < PAGE_BYTES; gi++) begin : g_page
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          pg_data[gi] <= DATA_RST;
          pg_valid_q[gi] <= 1'b0;
        end else if (latch_en && (addr_q[PAGE_W-1:0] == PAGE_W'(gi))) begin
          // Later bytes at a wrapped offset replace earlier ones
          pg_data[gi] <= shift_q;
          pg_valid_q[gi] <= 1'b1;
        end else if ((start_c && !busy_q) || (prog_q && (prog_idx_q == 4'hF))) begin
          // A Start before the Stop abandons the latched bytes
          pg_valid_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Programming launches only from a Stop after data bytes
  assign launch = stop_c && !busy_q && !dir_q && (|pg_valid_q) && !wp_f;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prog_q <= 1'b0;
      prog_idx_q <= 4'h0;
      prog_page_q <= '0;
      tmr_q <= '0;
      busy_q <= 1'b0;
    end else if (launch) begin
      prog_q <= 1'b1;
      prog_idx_q <= 4'h0;
      prog_page_q <= addr_q[ADDR_W-1:PAGE_W];
      busy_q <= 1'b1;
    end else if (prog_q) begin
      prog_idx_q <= prog_idx_q + 4'h1;
      if (prog_idx_q == 4'hF) begin
        prog_q <= 1'b0;
        tmr_q <= TMR_LOAD;
      end
    end else if (busy_q) begin
      // Self-timed cycle; address bytes not acknowledged until it ends
      if (tmr_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        tmr_q <= tmr_q - TMR_W'(1);
      end
    end
  end

  tws_mem u_mem (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(prog_q && pg_valid_q[prog_idx_q]),
    .wr_addr({prog_page_q, prog_idx_q}),
    .wr_data(pg_data[prog_idx_q]),
    .rd_addr(addr_q),
    .rd_data_q(rd_data)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      standby_q <= 1'b1;
    end else begin
      standby_q <= (state_q == TWS_IDLE) && !busy_q;
    end
  end
  assign standby = standby_q;
  assign busy = busy_q;

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_drive_only_ack_tx: assert property (sda_oe_q |-> $past(state_q == TWS_ACK || state_q == TWS_TX))
    else $error("data line driven outside ack or transmit");
  a_start_resets: assert property (start_c |=> (state_q == TWS_RX) && (byte_q == 2'd0) && (bit_q == 4'd0))
    else $error("start did not reset the sequencer");
  a_stop_to_idle: assert property (stop_c && !start_c |=> state_q == TWS_IDLE)
    else $error("stop did not end the operation");
  a_busy_no_ack: assert property (byte_done && (byte_q == 2'd0) && busy_q |=> state_q == TWS_IGNORE)
    else $error("address acknowledged while programming");
  a_prefix_nack: assert property (byte_done && (byte_q == 2'd0) && (shift_q[7:4] != ARRAY_PREFIX)
    |=> (state_q == TWS_IGNORE) && !sda_oe_q)
    else $error("wrong prefix acknowledged");
  a_cs_nack: assert property (byte_done && (byte_q == 2'd0) && (shift_q[DEV_CS_BIT] != cs_f)
    |=> state_q == TWS_IGNORE)
    else $error("chip select mismatch acknowledged");
  a_ack_drives_low: assert property ((state_q == TWS_ACK) ##1 (state_q == TWS_ACK) |-> sda_oe_q)
    else $error("ack slot not pulled low");
  a_wp_no_prog: assert property (stop_c && wp_f && !busy_q |=> !busy_q && !prog_q)
    else $error("programming started under write protect");
  a_page_wrap: assert property (latch_en |=> (addr_q[ADDR_W-1:PAGE_W] == $past(addr_q[ADDR_W-1:PAGE_W]))
    && (addr_q[PAGE_W-1:0] == PAGE_W'($past(addr_q[PAGE_W-1:0]) + 4'd1)))
    else $error("page address did not wrap in page");
  a_read_incr: assert property (tx_done |=> addr_q == ADDR_W'($past(addr_q) + 10'h001))
    else $error("read did not advance the counter");
  // Helper count of consecutive programming cycles
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prog_len_q <= 5'h00;
    end else if (prog_q) begin
      prog_len_q <= prog_len_q + 5'h01;
    end else begin
      prog_len_q <= 5'h00;
    end
  end
  a_prog_len: assert property ($fell(prog_q) |-> prog_len_q == 5'h10)
    else $error("programming pass not sixteen cycles");
endmodule

// >>> tws_top_tb.sv
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/100ps
module tws_top_tb;
  import tws_pkg::*;
  localparam int WR = 400;
  logic sys_clk;
  logic rst;
  logic chip_select_pin;
  logic write_protect;
  logic scl;
  logic sda_rel;
  logic sda_out;
  logic sda_oe;
  logic busy;
  logic standby;
  logic k;
  logic [7:0] pg[$];
  wire sda_line;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  // Pull-up wins unless a party pulls low
  assign sda_line = sda_rel & ~(sda_oe & ~sda_out);
  tws_top #(.WR_CYCLES(WR)) dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .scl_in(scl),
    .sda_in(sda_line),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .chip_select_pin(chip_select_pin),
    .write_protect(write_protect),
    .busy(busy),
    .standby(standby)
  );
  tws_master m (
    .sys_clk(sys_clk),
    .sda_line(sda_line),
    .scl(scl),
    .sda_rel(sda_rel)
  );
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Byte or page write; a programming write is polled while it runs
  task automatic wr(input logic [9:0] a, input logic [7:0] d[$], input logic prog);
    int n;
    m.start();
    m.send({4'hA, 1'b0, a[9:8], 1'b0}, k);
    chk(k, 1'b1);
    m.send(a[7:0], k);
    chk(k, 1'b1);
    foreach (d[i]) begin
      m.send(d[i], k);
      chk(k, 1'b1);
    end
    m.stop();
    chk(busy, prog);
    if (prog) begin
      m.start();
      m.send({4'hA, 1'b0, a[9:8], 1'b0}, k);
      chk(k, 1'b0);
      m.stop();
    end
    n = 0;
    while (busy !== 1'b0 && n < 800) begin
      m.tick(1);
      n++;
    end
    m.tick(3);
    chk({busy, standby}, 2'b01);
  endtask
  // Current-address read of a run of bytes
  task automatic rd(input logic [7:0] exp[$]);
    logic [7:0] q;
    m.start();
    m.send(8'hA1, k);
    chk(k, 1'b1);
    foreach (exp[i]) begin
      m.recv(i < exp.size() - 1, q);
      chk(q, exp[i]);
    end
    m.stop();
    m.tick(4);
    chk(standby, 1'b1);
  endtask
  initial begin
    rst = 1'b1;
    chip_select_pin = 1'b0;
    write_protect = 1'b0;
    repeat (8) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    m.tick(6);
    chk({standby, sda_out}, 2'b10);
    // Clocking a byte with no Start draws nothing
    m.send(8'hA0, k);
    chk(k, 1'b0);
    $display("test no start done");
    m.start();
    m.send(8'hA8, k);
    chk(k, 1'b0);
    m.send(8'h00, k);
    chk(k, 1'b0);
    m.start();
    m.send(8'hB0, k);
    chk(k, 1'b0);
    chip_select_pin = 1'b1;
    m.start();
    m.send(8'hA8, k);
    chk(k, 1'b1);
    m.stop();
    chk(busy, 1'b0);
    chip_select_pin = 1'b0;
    $display("test address filter done");
    wr(10'h123, '{8'h5A}, 1'b1);
    for (int i = 0; i < 17; i++) begin
      pg.push_back(8'h10 + 8'(i));
    end
    // Seventeenth byte lands back on offset 0
    wr(10'h120, pg, 1'b1);
    // Last byte of the page wraps the counter back to offset 0
    wr(10'h12F, '{8'h3C}, 1'b1);
    rd('{8'h20, 8'h11, 8'h12, 8'h13});
    $display("test page write done");
    wr(10'h3FF, '{8'hC3}, 1'b1);
    write_protect = 1'b1;
    wr(10'h3FF, '{8'h77}, 1'b0);
    write_protect = 1'b0;
    wr(10'h000, '{8'h5E}, 1'b1);
    wr(10'h3FE, '{8'h01}, 1'b1);
    rd('{8'hC3, 8'h5E});
    $display("test protect and wrap done");
    results();
  end
  // Hang guard, well above the expected run length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      $display("timeout at %0t", $time);
      results();
    end
  end
endmodule
